//--- dio_filt_pkg.sv
// constants and carrier types for the input conditioning block
package dio_filt_pkg;
    // ------------------------------------------------------------
    // line count and register layout
    // ------------------------------------------------------------
    localparam int NUM_LINES = 32;
    localparam int FILT_EN_BIT = 1;
    localparam int EDGE_EN_BIT = 2;
    localparam int SRQ_EDGE_BIT = 0;
    localparam int STATUS_EDGE_BIT = 0;
    localparam logic [31:0] RELOAD_RST = 32'hffff_ffff;
    localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
    localparam logic [7:0] STATUS_RST = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_KHZ = 25000;
    localparam int FILT_CLK_KHZ = 12000;
    localparam logic [5:0] TICK_STEP = 6'(FILT_CLK_KHZ / 1000);
    localparam logic [5:0] TICK_MOD = 6'(SYS_CLK_KHZ / 1000);
    localparam logic [1:0] EXPIRE_NEED = 2'h2;
    localparam logic [2:0] PIN_IDLE = 3'h7;

    typedef struct packed {
        logic [31:0] pos_mask;
        logic [31:0] neg_mask;
        logic [31:0] int_en;
    } edge_cfg_t;

    typedef struct packed {
        logic wr;
        logic [31:0] data;
    } reg_wr_t;
endpackage

//--- dio_line_filter.sv
// one input line: synchroniser and two-expiry state validation
`timescale 1ns/1ps
module dio_line_filter
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_pin,
    input wire logic i_filt_en,
    input wire logic i_tick,
    input wire logic i_expire,
    output logic o_state
);
    import dio_filt_pkg::*;

    logic [2:0] sync_ff;
    logic level_ff;
    logic cand_ff;
    logic stable_ff;
    logic [1:0] hits_ff;

    // ------------------------------------------------------------
    // synchroniser, level moves when stages two and three agree
    // ------------------------------------------------------------
    wire agree_w = (sync_ff[1] == sync_ff[2]);

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync_ff <= PIN_IDLE;
            level_ff <= 1'b1;
        end
        else
        begin
            sync_ff <= {sync_ff[1:0], i_pin};
            if (agree_w)
                level_ff <= sync_ff[2];
        end
    end

    // ------------------------------------------------------------
    // validation on filter expiries
    // ------------------------------------------------------------
    wire moved_w = (level_ff != cand_ff);
    wire pending_w = (cand_ff != stable_ff);
    wire [1:0] hits_inc_w = hits_ff + 2'h1;
    wire accept_w = i_expire && !moved_w && pending_w
        && (hits_inc_w >= EXPIRE_NEED);

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            cand_ff <= 1'b1;
            stable_ff <= 1'b1;
            hits_ff <= 2'h0;
        end
        else if (!i_filt_en)
        begin
            cand_ff <= level_ff;
            stable_ff <= level_ff;
            hits_ff <= 2'h0;
        end
        else if (i_tick && moved_w)
        begin
            cand_ff <= level_ff;
            hits_ff <= 2'h0;
        end
        else if (accept_w)
        begin
            stable_ff <= cand_ff;
            hits_ff <= 2'h0;
        end
        else if (i_expire)
            hits_ff <= pending_w ? hits_inc_w : 2'h0;
    end

    assign o_state = i_filt_en ? stable_ff : level_ff;

    a_stable_two_hits : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (i_filt_en && $past(i_filt_en) && $changed(stable_ff))
        |-> $past(accept_w))
        else $error("filtered state moved without two expiries");
endmodule

//--- dio_input_cond.sv
// input glitch filter and edge detection for the digital input bank
`timescale 1ns/1ps
module dio_input_cond
#(
    parameter int LINES = 32
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [LINES-1:0] i_pin,
    input wire logic [7:0] i_master_en,
    input wire logic [7:0] i_srq_enable,
    input wire dio_filt_pkg::edge_cfg_t i_edge_cfg,
    input wire dio_filt_pkg::reg_wr_t i_reload_wr,
    input wire dio_filt_pkg::reg_wr_t i_flag_wr,
    output logic [31:0] o_reload,
    output logic [LINES-1:0] o_flags,
    output logic [LINES-1:0] o_inputs,
    output logic [7:0] o_status_byte,
    output logic o_srq
);
    import dio_filt_pkg::*;

    generate
        if (LINES != NUM_LINES)
        begin : g_bad_lines
            $error("LINES must equal the register width");
        end
    endgenerate

    logic [31:0] reload_ff;
    logic [5:0] acc_ff;
    logic [31:0] cnt_ff;
    logic [LINES-1:0] prev_ff;
    logic [LINES-1:0] flags_ff;
    logic [7:0] status_ff;
    logic srq_ff;
    logic [LINES-1:0] state_w;

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    wire filt_en_w = i_master_en[FILT_EN_BIT];
    wire edge_en_w = i_master_en[EDGE_EN_BIT];
    wire srq_en_w = i_srq_enable[SRQ_EDGE_BIT];

    // ------------------------------------------------------------
    // filter timer register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            reload_ff <= RELOAD_RST;
        else if (i_reload_wr.wr)
            reload_ff <= i_reload_wr.data;
    end

    // 2^32 minus the register value gives the interval in periods
    wire [31:0] period_w = 32'h0000_0000 - reload_ff;

    // ------------------------------------------------------------
    // 12 MHz tick from the 25 MHz clock by phase accumulation
    // ------------------------------------------------------------
    wire [5:0] acc_sum_w = acc_ff + TICK_STEP;
    wire tick_w = (acc_sum_w >= TICK_MOD);
    wire [5:0] nxt_acc = tick_w ? acc_sum_w - TICK_MOD : acc_sum_w;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            acc_ff <= 6'h00;
        else
            acc_ff <= nxt_acc;
    end

    // ------------------------------------------------------------
    // shared interval down-counter
    // ------------------------------------------------------------
    // a count of one or zero on this tick is an expiry
    wire expire_w = filt_en_w && tick_w && (cnt_ff <= 32'h0000_0001);
    wire [31:0] cnt_dec_w = cnt_ff - 32'h0000_0001;
    wire [31:0] nxt_cnt = !filt_en_w ? period_w
        : expire_w ? period_w
        : tick_w ? cnt_dec_w
        : cnt_ff;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            cnt_ff <= 32'h0000_0000;
        else
            cnt_ff <= nxt_cnt;
    end

    // ------------------------------------------------------------
    // per-line conditioning
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++)
        begin : g_line
            dio_line_filter u_line
            (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_pin(i_pin[gi]),
                .i_filt_en(filt_en_w),
                .i_tick(tick_w),
                .i_expire(expire_w),
                .o_state(state_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // edge detection and sticky flags
    // ------------------------------------------------------------
    wire [LINES-1:0] rise_w = state_w & ~prev_ff;
    wire [LINES-1:0] fall_w = ~state_w & prev_ff;
    wire [LINES-1:0] edge_w = (rise_w & i_edge_cfg.pos_mask)
        | (fall_w & i_edge_cfg.neg_mask);
    // set flag masks its own line until cleared
    wire [LINES-1:0] hit_w = edge_w & ~flags_ff
        & {LINES{edge_en_w}};
    wire [LINES-1:0] clr_w = i_flag_wr.wr ? i_flag_wr.data
        : {LINES{1'b0}};
    wire [LINES-1:0] kept_w = flags_ff & ~clr_w;
    // a set in the clearing cycle survives
    wire [LINES-1:0] nxt_flags = kept_w | hit_w;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            prev_ff <= {LINES{1'b1}};
            flags_ff <= FLAGS_RST;
        end
        else
        begin
            prev_ff <= state_w;
            flags_ff <= nxt_flags;
        end
    end

    // ------------------------------------------------------------
    // status byte and service request
    // ------------------------------------------------------------
    wire any_flag_w = |nxt_flags;
    wire srq_gate_w = srq_en_w && edge_en_w;
    wire new_req_w = srq_gate_w
        && (|(hit_w & i_edge_cfg.int_en));
    wire reissue_w = srq_gate_w && i_flag_wr.wr
        && (|(kept_w & i_edge_cfg.int_en));
    wire [7:0] nxt_status = {7'h00, any_flag_w} << STATUS_EDGE_BIT;

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            status_ff <= STATUS_RST;
            srq_ff <= 1'b0;
        end
        else
        begin
            status_ff <= nxt_status;
            srq_ff <= new_req_w || reissue_w;
        end
    end

    assign o_reload = reload_ff;
    assign o_flags = flags_ff;
    assign o_inputs = state_w;
    assign o_status_byte = status_ff;
    assign o_srq = srq_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_timer_idle_off : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !filt_en_w |=> cnt_ff == $past(period_w))
        else $error("timer not parked while filter is off");

    a_timer_reload : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        expire_w |=> cnt_ff == $past(period_w))
        else $error("timer did not reload at expiry");

    a_timer_step : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (filt_en_w && tick_w && !expire_w)
        |=> cnt_ff == $past(cnt_dec_w))
        else $error("timer did not decrement by one on tick");

    a_timer_still : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (filt_en_w && !tick_w) |=> $stable(cnt_ff))
        else $error("timer moved without a tick");

    a_tick_spacing : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (!tick_w ##1 !tick_w) |=> tick_w ##1 !tick_w)
        else $error("filter tick pattern off the 12 of 25 rate");

    a_flag_sticky : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !i_flag_wr.wr |=> (flags_ff & $past(flags_ff))
        == $past(flags_ff))
        else $error("flag dropped without a clearing write");

    a_flag_set : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (|hit_w) |=> (flags_ff & $past(hit_w)) == $past(hit_w))
        else $error("detected edge did not set its flag");

    a_flag_quiet : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        !edge_en_w |=> (flags_ff & ~$past(flags_ff)) == '0)
        else $error("flag set while edge detection is off");

    a_flag_clear : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (i_flag_wr.wr && hit_w == '0) |=> flags_ff == $past(kept_w))
        else $error("write-one clear gave wrong flags");

    a_status_or : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        o_status_byte[STATUS_EDGE_BIT] == (|flags_ff))
        else $error("status bit does not follow the flags");

    a_srq_gated : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        o_srq |-> $past(srq_gate_w))
        else $error("service request without its enables");

    a_tick_apart : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        tick_w |=> !tick_w)
        else $error("two filter ticks on adjacent clocks");

    a_srq_on_edge : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (srq_en_w && edge_en_w
        && |(nxt_flags & ~flags_ff & i_edge_cfg.int_en)) |=> o_srq)
        else $error("new enabled flag gave no service request");

    a_srq_reissue : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (srq_en_w && edge_en_w && i_flag_wr.wr
        && |(flags_ff & ~i_flag_wr.data & i_edge_cfg.int_en)) |=> o_srq)
        else $error("flags left set gave no new service request");

    a_srq_has_flag : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        o_srq |-> |(flags_ff & $past(i_edge_cfg.int_en)))
        else $error("service request without an enabled flag");

    a_status_spare : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (o_status_byte & ~(8'h01 << STATUS_EDGE_BIT)) == 8'h00)
        else $error("unused status bits not zero");

    a_state_at_expiry : assert property (@(posedge i_clk_sys)
        disable iff (i_rst)
        (filt_en_w && $past(filt_en_w) && state_w != $past(state_w))
        |-> $past(expire_w))
        else $error("filtered state moved away from an expiry");

    c_expiry : cover property (@(posedge i_clk_sys)
        disable iff (i_rst) expire_w ##[1:40] expire_w);
    c_edge_request : cover property (@(posedge i_clk_sys)
        disable iff (i_rst) new_req_w ##1 o_srq);
    c_reissue : cover property (@(posedge i_clk_sys)
        disable iff (i_rst) reissue_w);
    c_clear_all : cover property (@(posedge i_clk_sys)
        disable iff (i_rst) o_status_byte[0] ##1 !o_status_byte[0]);
    c_filter_accept : cover property (@(posedge i_clk_sys)
        disable iff (i_rst) filt_en_w && state_w != $past(state_w));
endmodule

//--- field_lines.sv
// field-side model of the isolated input lines
`timescale 1ns/1ps
module field_lines
(
    input wire logic i_clk_sys,
    output logic [31:0] o_pin
);
    // ------------------------------------------------------------
    // lines idle open, so they read high
    // ------------------------------------------------------------
    initial
        o_pin = 32'hffff_ffff;

    task automatic set_low(input logic [31:0] low_mask);
        @(posedge i_clk_sys);
        #1;
        o_pin = ~low_mask;
    endtask

    task automatic pulse(input logic [31:0] low_mask, input int width);
        set_low(low_mask);
        repeat (width) @(posedge i_clk_sys);
        #1;
        o_pin = 32'hffff_ffff;
    endtask
endmodule

//--- dio_input_cond_tb.sv
// self-checking bench for the input conditioning block
`timescale 1ns/1ps
module dio_input_cond_tb;
    import dio_filt_pkg::*;
    logic i_clk_sys;
    logic i_rst;
    logic [31:0] pins;
    logic [7:0] master_en;
    logic [7:0] srq_en;
    edge_cfg_t cfg;
    reg_wr_t reload_wr;
    reg_wr_t flag_wr;
    logic [31:0] o_reload;
    logic [31:0] o_flags;
    logic [31:0] o_inputs;
    logic [7:0] o_status_byte;
    logic o_srq;
    logic [31:0] lfsr;
    int mismatches;
    int checks;
    int srq_cnt;

    dio_input_cond #(.LINES(NUM_LINES)) dut
    (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_pin(pins),
        .i_master_en(master_en),
        .i_srq_enable(srq_en),
        .i_edge_cfg(cfg),
        .i_reload_wr(reload_wr),
        .i_flag_wr(flag_wr),
        .o_reload(o_reload),
        .o_flags(o_flags),
        .o_inputs(o_inputs),
        .o_status_byte(o_status_byte),
        .o_srq(o_srq)
    );

    field_lines field
    (
        .i_clk_sys(i_clk_sys),
        .o_pin(pins)
    );

    // ------------------------------------------------------------
    // clock, request counter, watchdog
    // ------------------------------------------------------------
    initial
    begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    always @(posedge i_clk_sys)
        if (o_srq === 1'b1)
            srq_cnt++;

    initial
    begin
        #(5000 * 40);
        mismatches++;
        test_done();
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic [31:0] exp_left(input logic [31:0] f,
                                             input logic [31:0] c);
        return f & ~c;
    endfunction

    function automatic logic [31:0] exp_status(input logic [31:0] f);
        return {31'h0, |f};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // only the selected strobe moves, so back-to-back writes to different registers never
    // assign one struct twice in the same time step
    task automatic wr(input logic sel, input logic [31:0] d);
        if (sel)
            flag_wr = '{1'b1, d};
        else
            reload_wr = '{1'b1, d};
        step(1);
        if (sel)
            flag_wr.wr = 1'b0;
        else
            reload_wr.wr = 1'b0;
    endtask

    task automatic wait_in(input logic [31:0] exp, input int n);
        for (int i = 0; i < n && o_inputs !== exp; i++)
            step(1);
        cmp(o_inputs, exp);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] m;
        logic [31:0] c;
        lfsr = 32'h0000_65ca;
        mismatches = 0;
        checks = 0;
        srq_cnt = 0;
        master_en = 8'h00;
        srq_en = 8'h01;
        cfg = '0;
        flag_wr = '0;
        reload_wr = '0;
        i_rst = 1'b1;
        step(16);
        i_rst = 1'b0;
        step(1);
        cmp(o_reload, RELOAD_RST);
        cmp(o_flags, FLAGS_RST);
        cmp(o_inputs, 32'hffff_ffff);
        cmp(32'(o_status_byte), 32'(STATUS_RST));
        $display("test reset done");

        m = rnd() | 32'h0000_0001;
        master_en = 8'h04;
        cfg = '{32'h0, m, m};
        field.set_low(m);
        step(8);
        cmp(o_flags, m);
        cmp(32'(o_status_byte), exp_status(m));
        cmp(32'(srq_cnt), 32'h1);
        cfg.pos_mask = 32'hffff_ffff;
        field.set_low(32'h0);
        step(8);
        cmp(o_flags, m);
        c = rnd() & m & 32'hffff_fffe;
        wr(1'b1, c);
        step(1);
        cmp(o_flags, exp_left(m, c));
        cmp(32'(srq_cnt), 32'h2);
        wr(1'b1, o_flags);
        step(1);
        cmp(o_flags, 32'h0);
        cmp(32'(o_status_byte), 32'h0);
        field.set_low(m);
        step(8);
        cmp(o_flags, m);
        cmp(32'(srq_cnt), 32'h3);
        $display("test edge done");

        master_en = 8'h00;
        field.set_low(32'h0);
        step(8);
        wr(1'b1, 32'hffff_ffff);
        field.set_low(m);
        step(8);
        cmp(o_flags, 32'h0);
        master_en = 8'h04;
        srq_en = 8'h00;
        field.set_low(32'h0);
        step(8);
        cmp(o_flags, m);
        cmp(32'(srq_cnt), 32'h3);
        wr(1'b1, 32'hffff_ffff);
        srq_en = 8'h01;
        $display("test gate done");

        master_en = 8'h00;
        cfg = '{32'h0, 32'hffff_ffff, 32'h0};
        wr(1'b0, 32'hffff_fffc);
        step(1);
        cmp(o_reload, 32'hffff_fffc);
        master_en = 8'h06;
        m = rnd() | 32'h0000_0001;
        field.pulse(m, 3);
        for (int i = 0; i < 40; i++)
        begin
            step(1);
            cmp(o_inputs, 32'hffff_ffff);
        end
        cmp(o_flags, 32'h0);
        field.set_low(m);
        wait_in(~m, 30);
        step(2);
        cmp(o_flags, m);
        field.set_low(32'h0);
        wait_in(32'hffff_ffff, 30);
        wr(1'b1, 32'hffff_ffff);
        master_en = 8'h04;
        field.pulse(m, 3);
        step(8);
        cmp(o_flags, m);
        $display("test filter done");
        test_done();
    end
endmodule
